// [hdl/acrb_pkg.sv]
// package: register map, field layout, reset values and codes of the converter control bank
package acrb_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CHANNEL_SELECT  = 8'h05;
  localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_STAB      = 8'h09;
  localparam logic [7:0] ADDR_PLL_LOCK        = 8'h0a;
  localparam logic [7:0] ADDR_CLOCK_DIVIDER   = 8'h0b;
  localparam logic [7:0] ADDR_TEST_PATTERN    = 8'h0d;
  localparam logic [7:0] ADDR_SELF_TEST       = 8'h0e;
  localparam logic [7:0] ADDR_SHADOW_UPDATE   = 8'hff;
  localparam logic [7:0] ADDR_SHADOW_FIRST    = 8'h08;
  localparam logic [7:0] ADDR_SHADOW_LAST     = 8'h79;
  localparam logic [7:0] SHADOW_UPDATE_CMD    = 8'h01;

  // reset values
  localparam logic [7:0] RST_CHANNEL_SELECT   = 8'h03;
  localparam logic [7:0] RST_POWER_CONTROL    = 8'h00;
  localparam logic [7:0] RST_CLOCK_STAB       = 8'h01;
  localparam logic [7:0] RST_CLOCK_DIVIDER    = 8'h00;
  localparam logic [7:0] RST_TEST_PATTERN     = 8'h00;
  localparam logic [7:0] RST_SELF_TEST        = 8'h00;

  // writable bits of each register, open bits read as zero
  localparam logic [7:0] MASK_CHANNEL_SELECT  = 8'h03;
  localparam logic [7:0] MASK_POWER_CONTROL   = 8'h23;
  localparam logic [7:0] MASK_CLOCK_STAB      = 8'h01;
  localparam logic [7:0] MASK_CLOCK_DIVIDER   = 8'h3f;
  localparam logic [7:0] MASK_TEST_PATTERN    = 8'hbf;
  localparam logic [7:0] MASK_SELF_TEST       = 8'h05;

  // field positions
  localparam int POS_EXT_PIN_STANDBY = 5;
  localparam int POS_INT_POWER_LO    = 0;
  localparam int POS_DCS_ENABLE      = 0;
  localparam int POS_PLL_LOCKED      = 7;
  localparam int POS_DIV_RATIO_LO    = 0;
  localparam int POS_DIV_PHASE_LO    = 3;
  localparam int POS_TEST_CODE_LO    = 0;
  localparam int POS_RST_SHORT_PN    = 4;
  localparam int POS_RST_LONG_PN     = 5;
  localparam int POS_USER_SINGLE     = 7;
  localparam int POS_SELF_TEST_CONTROL     = 0;
  localparam int POS_BIST_RESTART    = 2;

  localparam int DATA_W   = 14;
  localparam int CHANNELS = 2;

  // pattern generator lengths and taps
  localparam int LONG_PN_LEN  = 23;
  localparam int LONG_PN_TAP  = 18;
  localparam int SHORT_PN_LEN = 9;
  localparam int SHORT_PN_TAP = 5;

  // fixed test words
  localparam logic [DATA_W-1:0] WORD_MIDSCALE   = 14'h2000;
  localparam logic [DATA_W-1:0] WORD_POS_FULL   = 14'h3fff;
  localparam logic [DATA_W-1:0] WORD_NEG_FULL   = 14'h0000;
  localparam logic [DATA_W-1:0] WORD_CHECKER_A  = 14'h2aaa;
  localparam logic [DATA_W-1:0] WORD_CHECKER_B  = 14'h1555;

  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'b00,
    PWR_DOWN    = 2'b01,
    PWR_STANDBY = 2'b10,
    PWR_RSVD    = 2'b11
  } acrb_power_e;

  typedef enum logic [3:0] {
    TST_OFF       = 4'h0,
    TST_MIDSCALE  = 4'h1,
    TST_POS_FULL  = 4'h2,
    TST_NEG_FULL  = 4'h3,
    TST_CHECKER   = 4'h4,
    TST_LONG_PN   = 4'h5,
    TST_SHORT_PN  = 4'h6,
    TST_TOGGLE    = 4'h7,
    TST_USER      = 4'h8,
    TST_RAMP      = 4'hf
  } acrb_test_e;

  // one channel's local register pair
  typedef struct packed {
    logic [7:0] power;
    logic [7:0] test;
  } acrb_chan_s;

  // global shadowed registers
  typedef struct packed {
    logic [7:0] stab;
    logic [7:0] div;
    logic [7:0] bist;
  } acrb_glob_s;

endpackage

// [hdl/acrb_clk_div.sv]
// clock divider with phase delay, produces the sample-enable tick
`timescale 1ns/100ps
module acrb_clk_div
  import acrb_pkg::*;
(
  // clock and control
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ce_in,
  // divider settings
  input  wire logic [2:0] ratio_in,
  input  wire logic [2:0] phase_in,
  // tick
  output logic            tick_out
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [6:0] delay_q;
  logic       base_tick;

  // one tick every ratio+1 input cycles
  assign base_tick = (cnt_q == 3'h0);
  assign cnt_d     = (cnt_q >= ratio_in) ? 3'h0 : cnt_q + 3'h1;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_q   <= 3'h0;
      delay_q <= 7'h00;
    end else if (ce_in) begin
      cnt_q   <= cnt_d;
      delay_q <= {delay_q[5:0], base_tick};
    end
  end

  // delay of phase input cycles taken from a tap of the shift line
  assign tick_out = (phase_in == 3'h0) ? base_tick : delay_q[phase_in - 3'h1];

  chk_div_period: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (ce_in && ratio_in == 3'h1 && $stable(ratio_in) && base_tick) |=> !base_tick)
    else $error("divide by two ticked twice in a row");

  chk_phase_tap: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (phase_in == 3'h1 && $past(ce_in)) |-> (tick_out == $past(base_tick)))
    else $error("phase one did not delay the tick by one cycle");

endmodule // acrb_clk_div

// [hdl/acrb_pattern.sv]
// per-channel test data generator and output select
`timescale 1ns/100ps
module acrb_pattern
  import acrb_pkg::*;
(
  // clock and control
  input  wire logic              ref_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              ce_in,
  input  wire logic              tick_in,
  // active test settings
  input  wire logic [7:0]        test_in,
  input  wire logic [15:0]       user_pat1_in,
  input  wire logic [15:0]       user_pat2_in,
  // data
  input  wire logic [DATA_W-1:0] sample_in,
  output logic [DATA_W-1:0]      data_out
);

  logic [LONG_PN_LEN-1:0]  long_q;
  logic [SHORT_PN_LEN-1:0] short_q;
  logic [DATA_W-1:0]       ramp_q;
  logic                    phase_q;
  logic                    user_done_q;
  logic [DATA_W-1:0]       data_q;
  logic [DATA_W-1:0]       pattern;
  logic [DATA_W-1:0]       user_word;
  logic [3:0]              code;
  logic                    single;
  logic                    step;

  assign code   = test_in[POS_TEST_CODE_LO +: 4];
  assign single = test_in[POS_USER_SINGLE];
  assign step   = ce_in && tick_in;

  // user words are 16 bits wide, the top two bits are dropped
  assign user_word = user_done_q ? WORD_NEG_FULL :
                     (phase_q ? user_pat2_in[DATA_W-1:0] : user_pat1_in[DATA_W-1:0]);

  always_comb begin
    case (code)
      TST_MIDSCALE: pattern = WORD_MIDSCALE;
      TST_POS_FULL: pattern = WORD_POS_FULL;
      TST_NEG_FULL: pattern = WORD_NEG_FULL;
      TST_CHECKER:  pattern = phase_q ? WORD_CHECKER_B : WORD_CHECKER_A;
      TST_LONG_PN:  pattern = long_q[DATA_W-1:0];
      TST_SHORT_PN: pattern = {short_q, short_q[SHORT_PN_LEN-1 -: DATA_W-SHORT_PN_LEN]};
      TST_TOGGLE:   pattern = phase_q ? WORD_NEG_FULL : WORD_POS_FULL;
      TST_USER:     pattern = user_word;
      TST_RAMP:     pattern = ramp_q;
      default:      pattern = WORD_NEG_FULL;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      long_q      <= '1;
      short_q     <= '1;
      ramp_q      <= '0;
      phase_q     <= 1'b0;
      user_done_q <= 1'b0;
      data_q      <= '0;
    end else if (step) begin
      // reset bits hold the generators at their seed while set
      long_q  <= test_in[POS_RST_LONG_PN] ? '1 :
                 {long_q[LONG_PN_LEN-2:0], long_q[LONG_PN_LEN-1] ^ long_q[LONG_PN_TAP-1]};
      short_q <= test_in[POS_RST_SHORT_PN] ? '1 :
                 {short_q[SHORT_PN_LEN-2:0], short_q[SHORT_PN_LEN-1] ^ short_q[SHORT_PN_TAP-1]};
      ramp_q  <= ramp_q + 14'h0001;
      phase_q <= ~phase_q;
      // a single user pass ends after both words; leaving user mode rearms it
      user_done_q <= (code == TST_USER) && single && (user_done_q || phase_q);
      data_q  <= (code == TST_OFF) ? sample_in : pattern;
    end
  end

  assign data_out = data_q;

  chk_test_select: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (step && code == TST_MIDSCALE) |=> (data_q == WORD_MIDSCALE))
    else $error("midscale code did not replace the samples");

  chk_normal_path: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (step && code == TST_OFF) |=> (data_q == $past(sample_in)))
    else $error("samples not passed with test off");

endmodule // acrb_pattern

// [hdl/acrb_reg_bank.sv]
// control register bank of the dual-channel converter: shadowed local and global registers
//
// Operation
// - register bit picks power-down or standby for pin
// - two-bit power field: normal, down, standby
// - divider field divides input clock by code+1
// - phase field delays divided clock by code cycles
// - nonzero divider forces duty stabilizer on
// - four-bit test field selects fixed test patterns
// - code 1000 user pattern, 1111 ramp
// - nonzero test code replaces converter samples
// - separate generator resets and user single/repeat bit
// - shadow writes act only after transfer command
// - channel bits steer writes, both read channel A
`timescale 1ns/100ps
module acrb_reg_bank
  import acrb_pkg::*;
(
  // clock and reset
  input  wire logic                            ref_clk_in,
  input  wire logic                            sys_rst_in,
  input  wire logic                            ce_in,
  input  wire logic                            soft_reset_in,
  // register port
  input  wire logic                            reg_wr_in,
  input  wire logic                            reg_rd_in,
  input  wire logic [7:0]                      reg_addr_in,
  input  wire logic [7:0]                      reg_wdata_in,
  output logic [7:0]                           reg_rdata_out,
  output logic                                 reg_rvalid_out,
  // pins and analog status
  input  wire logic                            pdwn_pin_in,
  input  wire logic                            pll_locked_in,
  // user patterns and samples
  input  wire logic [15:0]                     user_pat1_in,
  input  wire logic [15:0]                     user_pat2_in,
  input  wire logic [CHANNELS-1:0][DATA_W-1:0] sample_in,
  // controls to the converter
  output logic [CHANNELS-1:0][1:0]             chan_power_out,
  output logic                                 dcs_active_out,
  output logic                                 sample_tick_out,
  output logic                                 self_test_control_out,
  output logic                                 bist_restart_out,
  output logic [CHANNELS-1:0][DATA_W-1:0]      data_out
);

  // true for the local registers that exist once per channel
  function automatic logic is_local(input logic [7:0] addr);
    return (addr == ADDR_POWER_CONTROL) || (addr == ADDR_TEST_PATTERN);
  endfunction

  logic                     rst;
  logic [1:0]               pdwn_sync_q;
  logic [1:0]               lock_sync_q;
  logic [7:0]               chan_sel_q;
  acrb_chan_s [CHANNELS-1:0] shadow_q;
  acrb_chan_s [CHANNELS-1:0] active_q;
  acrb_glob_s               gshadow_q;
  acrb_glob_s               gactive_q;
  logic                     xfer_q;
  logic [7:0]               rdata_q;
  logic                     rvalid_q;
  logic                     wr;
  logic                     rd;
  logic                     xfer_wr;
  logic                     pin_down;
  logic [7:0]               rd_mux;
  logic [7:0]               local_rd;
  logic [7:0]               wd_power;
  logic [7:0]               wd_test;

  // soft reset reloads every default as a full reset does, except the pin and lock synchronizers
  assign rst      = sys_rst_in || soft_reset_in;
  assign wr       = ce_in && reg_wr_in;
  assign rd       = ce_in && reg_rd_in;
  assign xfer_wr  = wr && (reg_addr_in == ADDR_SHADOW_UPDATE) &&
                    (reg_wdata_in == SHADOW_UPDATE_CMD);
  assign pin_down = pdwn_sync_q[1];
  assign wd_power = reg_wdata_in & MASK_POWER_CONTROL;
  assign wd_test  = reg_wdata_in & MASK_TEST_PATTERN;

  // pin and lock level come from outside the clock domain
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pdwn_sync_q <= 2'b00;
      lock_sync_q <= 2'b00;
    end else if (ce_in) begin
      pdwn_sync_q <= {pdwn_sync_q[0], pdwn_pin_in};
      lock_sync_q <= {lock_sync_q[0], pll_locked_in};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst) begin
      chan_sel_q <= RST_CHANNEL_SELECT;
    end else if (wr && reg_addr_in == ADDR_CHANNEL_SELECT) begin
      chan_sel_q <= reg_wdata_in & MASK_CHANNEL_SELECT;
    end
  end

  // per-channel shadow and active copies
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic chan_wr;
      assign chan_wr = wr && chan_sel_q[ch] && is_local(reg_addr_in);

      always_ff @(posedge ref_clk_in) begin
        if (rst) begin
          shadow_q[ch].power <= RST_POWER_CONTROL;
          shadow_q[ch].test  <= RST_TEST_PATTERN;
        end else if (chan_wr) begin
          if (reg_addr_in == ADDR_POWER_CONTROL) begin
            shadow_q[ch].power <= wd_power;
          end else begin
            shadow_q[ch].test <= wd_test;
          end
        end
      end

      always_ff @(posedge ref_clk_in) begin
        if (rst) begin
          active_q[ch].power <= RST_POWER_CONTROL;
          active_q[ch].test  <= RST_TEST_PATTERN;
        end else if (ce_in && xfer_q) begin
          active_q[ch] <= shadow_q[ch];
        end
      end

      // the pin overrides the internal field; its bit picks the state it forces
      assign chan_power_out[ch] = pin_down ?
          (active_q[ch].power[POS_EXT_PIN_STANDBY] ? PWR_STANDBY : PWR_DOWN) :
          active_q[ch].power[POS_INT_POWER_LO +: 2];

      acrb_pattern u_pattern (
        .ref_clk_in   (ref_clk_in),
        .sys_rst_in   (rst),
        .ce_in        (ce_in),
        .tick_in      (sample_tick_out),
        .test_in      (active_q[ch].test),
        .user_pat1_in (user_pat1_in),
        .user_pat2_in (user_pat2_in),
        .sample_in    (sample_in[ch]),
        .data_out     (data_out[ch])
      );
    end
  endgenerate

  // global shadow and active registers, not steered by the channel bits
  always_ff @(posedge ref_clk_in) begin
    if (rst) begin
      gshadow_q.stab <= RST_CLOCK_STAB;
      gshadow_q.div  <= RST_CLOCK_DIVIDER;
      gshadow_q.bist <= RST_SELF_TEST;
    end else if (wr) begin
      if (reg_addr_in == ADDR_CLOCK_STAB) begin
        gshadow_q.stab <= reg_wdata_in & MASK_CLOCK_STAB;
      end
      if (reg_addr_in == ADDR_CLOCK_DIVIDER) begin
        gshadow_q.div <= reg_wdata_in & MASK_CLOCK_DIVIDER;
      end
      if (reg_addr_in == ADDR_SELF_TEST) begin
        gshadow_q.bist <= reg_wdata_in & MASK_SELF_TEST;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst) begin
      gactive_q.stab <= RST_CLOCK_STAB;
      gactive_q.div  <= RST_CLOCK_DIVIDER;
      gactive_q.bist <= RST_SELF_TEST;
    end else if (ce_in && xfer_q) begin
      gactive_q <= gshadow_q;
    end
  end

  // transfer bit lives one cycle, then clears itself
  always_ff @(posedge ref_clk_in) begin
    if (rst) begin
      xfer_q <= 1'b0;
    end else if (ce_in) begin
      xfer_q <= xfer_wr;
    end
  end

  assign dcs_active_out = gactive_q.stab[POS_DCS_ENABLE] ||
                          (gactive_q.div[POS_DIV_RATIO_LO +: 3] != 3'h0);
  assign self_test_control_out  = gactive_q.bist[POS_SELF_TEST_CONTROL];
  assign bist_restart_out = gactive_q.bist[POS_BIST_RESTART];

  acrb_clk_div u_clk_div (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (rst),
    .ce_in      (ce_in),
    .ratio_in   (gactive_q.div[POS_DIV_RATIO_LO +: 3]),
    .phase_in   (gactive_q.div[POS_DIV_PHASE_LO +: 3]),
    .tick_out   (sample_tick_out)
  );

  // reads show the shadow side; with both channels selected channel A answers
  assign local_rd = chan_sel_q[0] ?
      ((reg_addr_in == ADDR_POWER_CONTROL) ? shadow_q[0].power : shadow_q[0].test) :
      ((reg_addr_in == ADDR_POWER_CONTROL) ? shadow_q[1].power : shadow_q[1].test);

  always_comb begin
    case (reg_addr_in)
      ADDR_CHANNEL_SELECT: rd_mux = chan_sel_q;
      ADDR_POWER_CONTROL:  rd_mux = local_rd;
      ADDR_TEST_PATTERN:   rd_mux = local_rd;
      ADDR_CLOCK_STAB:     rd_mux = gshadow_q.stab;
      ADDR_PLL_LOCK:       rd_mux = {lock_sync_q[1], 7'h00};
      ADDR_CLOCK_DIVIDER:  rd_mux = gshadow_q.div;
      ADDR_SELF_TEST:      rd_mux = gshadow_q.bist;
      ADDR_SHADOW_UPDATE:  rd_mux = {7'h00, xfer_q};
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else if (ce_in) begin
      rvalid_q <= reg_rd_in;
      if (rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst);

  sequence s_xfer_issued;
    xfer_wr ##1 (ce_in && xfer_q);
  endsequence

  sequence s_copy_done;
    (active_q[0] == $past(shadow_q[0])) && (gactive_q == $past(gshadow_q)) && !xfer_q;
  endsequence

  chk_pin_standby: assert property (
    (pin_down && active_q[0].power[POS_EXT_PIN_STANDBY]) |-> chan_power_out[0] == PWR_STANDBY)
    else $error("pin with standby bit did not give standby");

  chk_pin_powerdown: assert property (
    (pin_down && !active_q[1].power[POS_EXT_PIN_STANDBY]) |-> chan_power_out[1] == PWR_DOWN)
    else $error("pin with bit clear did not give power-down");

  chk_int_power: assert property (
    !pin_down |-> chan_power_out[0] == active_q[0].power[1:0])
    else $error("internal power field not followed");

  chk_dcs_forced: assert property (
    (gactive_q.div[2:0] != 3'h0) |-> dcs_active_out)
    else $error("stabilizer off with divider active");

  chk_shadow_hold: assert property (
    (wr && reg_addr_in == ADDR_CLOCK_DIVIDER && !xfer_q) |=> $stable(gactive_q.div))
    else $error("divider changed without transfer");

  chk_xfer_update: assert property (
    s_xfer_issued |=> s_copy_done)
    else $error("transfer did not copy shadow registers");

  chk_xfer_clear: assert property (
    (ce_in && xfer_q && !xfer_wr) |=> !xfer_q)
    else $error("transfer bit did not clear itself");

  chk_both_write: assert property (
    (wr && chan_sel_q == 8'h03 && reg_addr_in == ADDR_TEST_PATTERN) |=>
      (shadow_q[0].test == shadow_q[1].test))
    else $error("both-channel write reached one channel only");

  chk_both_read: assert property (
    (rd && chan_sel_q == 8'h03 && reg_addr_in == ADDR_POWER_CONTROL) |=>
      (reg_rdata_out == $past(shadow_q[0].power)))
    else $error("both-channel read did not return channel A");

  chk_power_both: assert property (
    (wr && chan_sel_q == 8'h03 && reg_addr_in == ADDR_POWER_CONTROL) |=>
      (shadow_q[0].power == shadow_q[1].power))
    else $error("power write missed a channel");

  chk_single_steer: assert property (
    (wr && chan_sel_q == 8'h01 && reg_addr_in == ADDR_POWER_CONTROL) |=>
      $stable(shadow_q[1].power))
    else $error("write leaked to channel B");

  chk_local_hold: assert property (
    (wr && is_local(reg_addr_in) && !xfer_q) |=> $stable(active_q))
    else $error("local write acted before transfer");

  chk_int_power_b: assert property (
    !pin_down |-> chan_power_out[1] == active_q[1].power[1:0])
    else $error("channel B power field not followed");

endmodule // acrb_reg_bank

// [verification/acrb_host.sv]
// host controller model driving the register strobe port
`timescale 1ns/100ps
module acrb_host
  import acrb_pkg::*;
(
  // clock
  input  wire logic       ref_clk_in,
  // answers
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  // requests
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // released lines show the inverse, so a stale value is never taken for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rvalid_in ? rdata_in : 8'hxx;
  endtask
  // callers never write power code 11, it is reserved
  task automatic xfer();
    wr(ADDR_SHADOW_UPDATE, SHADOW_UPDATE_CMD);
  endtask
endmodule // acrb_host

// [verification/acrb_reg_bank_bench.sv]
// self-checking bench of the converter control register bank
`timescale 1ns/100ps
module acrb_reg_bank_bench;
  import acrb_pkg::*;
  logic                            ref_clk_in    = 1'b0;
  logic                            sys_rst_in    = 1'b1;
  logic                            soft_reset_in = 1'b0;
  logic                            pdwn_pin_in   = 1'b0;
  logic                            pll_locked_in = 1'b0;
  logic [15:0]                     user_pat1_in  = 16'h0000;
  logic [15:0]                     user_pat2_in  = 16'h0000;
  logic [CHANNELS-1:0][DATA_W-1:0] sample_in     = '0;
  logic                            wr, rd, rvalid, dcs, tick, bist_en, bist_rs;
  logic [7:0]                      addr, wdata, rdata, rv;
  logic [CHANNELS-1:0][1:0]        chan_power;
  logic [CHANNELS-1:0][DATA_W-1:0] data_out;
  logic [DATA_W-1:0]               w0, w1;
  logic [7:0]                      sa [256];
  logic [7:0]                      sb [256];
  logic [7:0]                      aa [256];
  logic [7:0]                      ab [256];
  logic [7:0] regs [9] = '{8'h05, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'hff, 8'h07};
  logic [7:0] pats [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h0f, 8'h25,
                            8'h05, 8'h16, 8'h06, 8'h88};
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 14;
  int n;

  always #12.5 ref_clk_in = ~ref_clk_in;

  acrb_host host (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

  acrb_reg_bank dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
    .soft_reset_in(soft_reset_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .pdwn_pin_in(pdwn_pin_in), .pll_locked_in(pll_locked_in), .user_pat1_in(user_pat1_in),
    .user_pat2_in(user_pat2_in), .sample_in(sample_in), .chan_power_out(chan_power),
    .dcs_active_out(dcs), .sample_tick_out(tick), .self_test_control_out(bist_en),
    .bist_restart_out(bist_rs), .data_out(data_out));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // generous ceiling, the sequence needs well under two thousand cycles
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      summarize();
    end
  end

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: output got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      ADDR_CHANNEL_SELECT: msk = MASK_CHANNEL_SELECT;
      ADDR_POWER_CONTROL:  msk = MASK_POWER_CONTROL;
      ADDR_CLOCK_STAB:     msk = MASK_CLOCK_STAB;
      ADDR_CLOCK_DIVIDER:  msk = MASK_CLOCK_DIVIDER;
      ADDR_TEST_PATTERN:   msk = MASK_TEST_PATTERN;
      ADDR_SELF_TEST:      msk = MASK_SELF_TEST;
      default:             msk = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] ex(input logic [7:0] a);
    if (a == ADDR_PLL_LOCK) return {pll_locked_in, 7'h00};
    if (a == ADDR_POWER_CONTROL || a == ADDR_TEST_PATTERN) begin
      return sa[ADDR_CHANNEL_SELECT][0] ? sa[a] : sb[a];
    end
    return sa[a];
  endfunction

  function automatic logic [1:0] pw(input logic [7:0] r);
    return pdwn_pin_in ? (r[5] ? 2'b10 : 2'b01) : r[1:0];
  endfunction

  task automatic init_model();
    for (int i = 0; i < 256; i++) begin
      sa[i] = 8'h00;
      sb[i] = 8'h00;
    end
    sa[ADDR_CHANNEL_SELECT] = RST_CHANNEL_SELECT;
    sa[ADDR_CLOCK_STAB] = RST_CLOCK_STAB;
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_POWER_CONTROL || a == ADDR_TEST_PATTERN) begin
      if (sa[ADDR_CHANNEL_SELECT][0]) sa[a] = d & msk(a);
      if (sa[ADDR_CHANNEL_SELECT][1]) sb[a] = d & msk(a);
    end else begin
      sa[a] = d & msk(a);
    end
    host.wr(a, d);
  endtask

  task automatic chk(input logic [7:0] a);
    host.rd(a, rv);
    cmp_reg(rv, ex(a));
  endtask

  task automatic bxfer();
    host.xfer();
    aa = sa;
    ab = sb;
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic chk_pw();
    cmp_word(14'(chan_power[0]), 14'(pw(aa[ADDR_POWER_CONTROL])));
    cmp_word(14'(chan_power[1]), 14'(pw(ab[ADDR_POWER_CONTROL])));
  endtask

  initial begin
    init_model();
    aa = sa;
    ab = sb;
    repeat (6) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    foreach (regs[i]) chk(regs[i]);
    put(8'h0a, 8'hff);
    put(8'h07, 8'hff);
    put(ADDR_POWER_CONTROL, 8'h21);
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk_pw();
    foreach (regs[i]) chk(regs[i]);
    bxfer();
    chk_pw();
    put(ADDR_CHANNEL_SELECT, 8'h02);
    put(ADDR_POWER_CONTROL, 8'h22);
    put(ADDR_CHANNEL_SELECT, 8'h01);
    put(ADDR_POWER_CONTROL, 8'h00);
    bxfer();
    chk_pw();
    put(ADDR_CHANNEL_SELECT, 8'h03);
    chk(ADDR_POWER_CONTROL);
    @(posedge ref_clk_in);
    pdwn_pin_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk_pw();
    put(ADDR_CLOCK_STAB, 8'h00);
    for (int r = 0; r < 8; r++) begin
      put(ADDR_CLOCK_DIVIDER, {2'b00, ((r == 2) ? 3'h1 : 3'($random(seed))), 3'(r)});
      bxfer();
      cmp_word(14'(dcs), 14'(r != 0));
      // old ticks linger in the delay line for up to seven cycles
      repeat (14) @(posedge ref_clk_in);
      #1;
      n = 0;
      while (tick !== 1'b1 && n < 20) begin
        @(posedge ref_clk_in);
        #1;
        n++;
      end
      n = 0;
      do begin
        @(posedge ref_clk_in);
        #1;
        n++;
      end while (tick !== 1'b1 && n < 20);
      cmp_word(14'(n), 14'(r + 1));
    end
    put(ADDR_CLOCK_DIVIDER, 8'h00);
    @(posedge ref_clk_in);
    user_pat1_in <= 16'($random(seed));
    user_pat2_in <= 16'($random(seed));
    sample_in <= {14'($random(seed)), 14'($random(seed))};
    foreach (pats[i]) begin
      put(ADDR_TEST_PATTERN, pats[i]);
      bxfer();
      repeat (3) @(posedge ref_clk_in);
      #1;
      w0 = data_out[0];
      @(posedge ref_clk_in);
      #1;
      w1 = data_out[0];
      case (pats[i])
        8'h00: cmp_word(w0, sample_in[0]);
        8'h01: cmp_word(w0, WORD_MIDSCALE);
        8'h02: cmp_word(w0, WORD_POS_FULL);
        8'h03: cmp_word(w1, WORD_NEG_FULL);
        8'h04: cmp_word(w0 ^ w1, WORD_CHECKER_A ^ WORD_CHECKER_B);
        8'h07: cmp_word(w0 ^ w1, 14'h3fff);
        8'h08: cmp_word(w0 ^ w1, user_pat1_in[13:0] ^ user_pat2_in[13:0]);
        8'h0f: cmp_word(w1 - w0, 14'h0001);
        8'h05: cmp_word(w1[13:1], w0[12:0]);
        8'h06: cmp_word(w1[13:6], w0[12:5]);
        8'h88: cmp_word(w0 | w1, 14'h0000);
        default: cmp_word(w0 & w1, 14'h3fff);
      endcase
      cmp_word(data_out[1], pats[i] == 8'h00 ? sample_in[1] : w1);
    end
    put(ADDR_SELF_TEST, 8'hff);
    bxfer();
    cmp_word(14'({bist_en, bist_rs}), 14'h0003);
    chk(ADDR_SELF_TEST);
    @(posedge ref_clk_in);
    pll_locked_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    chk(ADDR_PLL_LOCK);
    @(posedge ref_clk_in);
    soft_reset_in <= 1'b1;
    @(posedge ref_clk_in);
    soft_reset_in <= 1'b0;
    init_model();
    foreach (regs[i]) chk(regs[i]);
    summarize();
  end
endmodule // acrb_reg_bank_bench
